// ### cpu_space_pkg.sv
// Package: CPU-space encodings, termination codes and bus request carriers
package cpu_space_pkg;

  // Function code lines
  localparam logic [2:0]  FC_CPU_SPACE   = 3'h7;
  // CPU space type field position and values
  localparam int          TYPE_LSB       = 16;
  localparam logic [3:0]  TYPE_BREAKPOINT_INSTRUCTION      = 4'h0;
  localparam logic [3:0]  TYPE_ACCESS    = 4'h1;
  localparam logic [3:0]  TYPE_COPROC    = 4'h2;
  // Field positions inside the address
  localparam int          BREAKPOINT_INSTRUCTION_NUM_LSB   = 2;
  localparam int          COPROCESSOR_IDENTIFIER_LSB       = 13;
  localparam logic [2:0]  MMU_COPROCESSOR_IDENTIFIER       = 3'h0;
  // Transfer size codes: byte, word
  localparam logic [1:0]  SIZE_BYTE      = 2'h1;
  localparam logic [1:0]  SIZE_WORD      = 2'h2;
  // Data-size acknowledge codes (active high here): 01 byte port, 10 word, 11 long
  localparam logic [1:0]  ACK_BYTE_PORT  = 2'h1;
  // Sampling window for a late bus error after acknowledge, in samples
  localparam logic [1:0]  LATE_SAMPLES   = 2'h1;

  // Request kinds
  typedef enum logic [1:0] {
    REQ_BREAKPOINT_INSTRUCTION   = 2'b00,
    REQ_COPROC = 2'b01,
    REQ_ACCESS = 2'b10,
    REQ_OTHER  = 2'b11
  } req_kind_t;

  // Termination results
  typedef enum logic [2:0] {
    TERM_NONE     = 3'b000,
    TERM_NORMAL   = 3'b001,
    TERM_BUS_ERR  = 3'b010,
    TERM_ILLEGAL  = 3'b011,
    TERM_RETRY    = 3'b100
  } term_t;

  // Request from the sequencer
  typedef struct packed {
    req_kind_t   kind;
    logic [2:0]  fc;        // Function code for ordinary accesses
    logic [31:0] addr;      // Ordinary address
    logic [2:0]  breakpoint_instruction_num;  // Breakpoint number
    logic [2:0]  coprocessor_identifier;      // Coprocessor identifier
    logic [7:0]  reg_sel;   // Register select
    logic [1:0]  size;
    logic        read;
  } bus_req_t;

  // Bus cycle outputs
  typedef struct packed {
    logic [2:0]  fc;
    logic [31:0] addr;
    logic [1:0]  size;
    logic        read;
    logic        strobe;    // Address strobe, active high internally
  } bus_out_t;

endpackage : cpu_space_pkg

// ### cpu_space_bus_termination.sv
// Bus controller for CPU-space cycles and asynchronous cycle termination
// Notes on behaviour
// - Every CPU-space access drives function code lines to all ones.
// - Breakpoint acknowledge is a CPU-space read, type zero, number on A4-A2.
// - Acknowledged breakpoint word replaces the opcode and is executed afterwards.
// - A byte-port answer to breakpoint acknowledge triggers a second byte cycle.
// - Bus error on breakpoint acknowledge raises an illegal instruction exception.
// - Coprocessor access: type 0010, identifier on A15-A13, register on A5-A0.
// - MMU answers as identifier zero; access checks use type 0001, select A7-A0.
// - Acknowledge alone ends the cycle normally and the bus continues.
// - Halt with or before acknowledge ends normally, then bus stops until release.
// - Bus error without halt, before or with acknowledge, gives bus error exception.
// - Bus error one sample after acknowledge, halt negated, still gives bus error.
// - Bus error with halt, before or with acknowledge, ends cycle then reruns it.
// - Bus error and halt one sample after acknowledge also retry the cycle.
// - Retry drops bus controls, waits release, reissues same address, code, size.
module cpu_space_bus_termination
  import cpu_space_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_clk_en,
  // Sequencer request
  input  wire logic        i_req_valid,
  input  wire bus_req_t    i_req,
  output logic             o_req_ready,
  // Bus pins (termination inputs active low)
  input  wire logic [1:0]  i_data_size_acknowledge_n,
  input  wire logic        i_bus_error_input_n,
  input  wire logic        i_halt_n,
  input  wire logic [15:0] i_data,
  output bus_out_t         o_bus,
  // Results toward the pipeline
  output logic             o_done,
  output term_t            o_term,
  output logic [15:0]      o_rd_data,
  output logic             o_pipe_insert,
  output logic             o_halted
);

  timeunit 1ns;
  timeprecision 1ns;

  // Bus controller states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WAIT  = 3'b001,
    ST_LATE  = 3'b010,
    ST_HOLD  = 3'b011,
    ST_RETRY = 3'b100
  } state_t;

  // Two-flop synchronisers for the asynchronous termination pins
  logic [3:0] term_meta_reg;
  logic [3:0] term_sync_reg;
  logic [15:0] data_meta_reg;
  logic [15:0] data_sync_reg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      term_meta_reg <= 4'h0;
      term_sync_reg <= 4'h0;
      data_meta_reg <= 16'h0000;
      data_sync_reg <= 16'h0000;
    end else if (i_clk_en) begin
      // Inverted so that 1 means asserted
      term_meta_reg <= {~i_halt_n, ~i_bus_error_input_n, ~i_data_size_acknowledge_n};
      term_sync_reg <= term_meta_reg;
      data_meta_reg <= i_data;
      data_sync_reg <= data_meta_reg;
    end
  end

  logic [1:0] ack;
  logic       bus_error_input;
  logic       halt;
  assign ack  = term_sync_reg[1:0];
  assign bus_error_input = term_sync_reg[2];
  assign halt = term_sync_reg[3];

  state_t      state_reg;
  bus_out_t    cyc_reg;          // Held access information for reruns
  req_kind_t   kind_reg;
  logic        second_byte_reg;
  logic        acked_reg;        // Acknowledge seen, late window open
  logic [1:0]  late_cnt_reg;
  logic        halt_seen_reg;    // Halt sampled with or before acknowledge
  logic [15:0] word_reg;

  // Address encoding of the incoming request
  bus_out_t req_bus;
  always_comb begin
    req_bus        = '0;
    req_bus.size   = i_req.size;
    req_bus.read   = i_req.read;
    req_bus.strobe = 1'b1;
    req_bus.fc     = FC_CPU_SPACE;
    unique case (i_req.kind)
      REQ_BREAKPOINT_INSTRUCTION: begin
        req_bus.addr[TYPE_LSB +: 4]     = TYPE_BREAKPOINT_INSTRUCTION;
        req_bus.addr[BREAKPOINT_INSTRUCTION_NUM_LSB +: 3] = i_req.breakpoint_instruction_num;
        req_bus.read                    = 1'b1;
        req_bus.size                    = SIZE_WORD;
      end
      REQ_COPROC: begin
        req_bus.addr[TYPE_LSB +: 4] = TYPE_COPROC;
        req_bus.addr[COPROCESSOR_IDENTIFIER_LSB +: 3] = i_req.coprocessor_identifier;
        req_bus.addr[5:0]           = i_req.reg_sel[5:0];
      end
      REQ_ACCESS: begin
        // Access-level check always targets the MMU identifier
        req_bus.addr[TYPE_LSB +: 4] = TYPE_ACCESS;
        req_bus.addr[COPROCESSOR_IDENTIFIER_LSB +: 3] = MMU_COPROCESSOR_IDENTIFIER;
        req_bus.addr[7:0]           = i_req.reg_sel;
      end
      REQ_OTHER: begin
        req_bus.fc   = i_req.fc;
        req_bus.addr = i_req.addr;
      end
    endcase
  end

  // Main cycle sequencer and termination decode
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      state_reg       <= ST_IDLE;
      cyc_reg         <= '0;
      kind_reg        <= REQ_OTHER;
      second_byte_reg <= 1'b0;
      acked_reg       <= 1'b0;
      late_cnt_reg    <= 2'h0;
      halt_seen_reg   <= 1'b0;
      word_reg        <= 16'h0000;
      o_done          <= 1'b0;
      o_term          <= TERM_NONE;
      o_rd_data       <= 16'h0000;
      o_pipe_insert   <= 1'b0;
      o_halted        <= 1'b0;
      o_req_ready     <= 1'b0;
    end else if (i_clk_en) begin
      o_done        <= 1'b0;
      o_pipe_insert <= 1'b0;
      o_req_ready   <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          o_halted <= halt;
          // Halt stops new cycles at the boundary
          if (i_req_valid && !halt && !bus_error_input) begin
            cyc_reg         <= req_bus;
            kind_reg        <= i_req.kind;
            second_byte_reg <= 1'b0;
            acked_reg       <= 1'b0;
            halt_seen_reg   <= 1'b0;
            o_req_ready     <= 1'b1;
            state_reg       <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (halt) begin
            halt_seen_reg <= 1'b1;
          end
          if (bus_error_input && (halt || halt_seen_reg)) begin
            cyc_reg.strobe <= 1'b0;
            state_reg      <= ST_RETRY;
          end else if (bus_error_input) begin
            cyc_reg.strobe <= 1'b0;
            o_done         <= 1'b1;
            o_term         <= (kind_reg == REQ_BREAKPOINT_INSTRUCTION) ? TERM_ILLEGAL : TERM_BUS_ERR;
            state_reg      <= ST_IDLE;
          end else if (ack != 2'h0) begin
            // Capture data, then keep sampling one more state for a late error
            if (second_byte_reg) begin
              word_reg[7:0] <= data_sync_reg[15:8];
            end else if (ack == ACK_BYTE_PORT && kind_reg == REQ_BREAKPOINT_INSTRUCTION) begin
              word_reg[15:8] <= data_sync_reg[15:8];
            end else begin
              word_reg <= data_sync_reg;
            end
            acked_reg      <= 1'b1;
            late_cnt_reg   <= LATE_SAMPLES;
            halt_seen_reg  <= halt_seen_reg | halt;
            cyc_reg.strobe <= 1'b0;
            state_reg      <= ST_LATE;
          end
        end
        ST_LATE: begin
          // One more sample: late bus error or late retry
          if (bus_error_input && halt) begin
            state_reg <= ST_RETRY;
          end else if (bus_error_input) begin
            o_done    <= 1'b1;
            o_term    <= (kind_reg == REQ_BREAKPOINT_INSTRUCTION) ? TERM_ILLEGAL : TERM_BUS_ERR;
            state_reg <= ST_IDLE;
          end else if (late_cnt_reg > 2'h1) begin
            late_cnt_reg <= late_cnt_reg - 2'h1;
          end else if (kind_reg == REQ_BREAKPOINT_INSTRUCTION && !second_byte_reg &&
                       ack == ACK_BYTE_PORT) begin
            // Byte port: gather remaining byte at next address
            second_byte_reg <= 1'b1;
            cyc_reg.addr    <= cyc_reg.addr + 32'h0000_0001;
            cyc_reg.size    <= SIZE_BYTE;
            state_reg       <= ST_HOLD;
          end else begin
            o_done    <= 1'b1;
            o_term    <= TERM_NORMAL;
            o_rd_data <= word_reg;
            o_pipe_insert <= (kind_reg == REQ_BREAKPOINT_INSTRUCTION);
            o_halted  <= halt_seen_reg | halt;
            state_reg <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          // Wait for responder to drop acknowledge before the next cycle
          if (ack == 2'h0 && !bus_error_input) begin
            cyc_reg.strobe <= 1'b1;
            acked_reg      <= 1'b0;
            state_reg      <= ST_WAIT;
          end
        end
        ST_RETRY: begin
          // Controls dropped; rerun same access once both released
          cyc_reg.strobe <= 1'b0;
          o_halted       <= halt;
          if (!bus_error_input && !halt) begin
            cyc_reg.strobe <= 1'b1;
            halt_seen_reg  <= 1'b0;
            acked_reg      <= 1'b0;
            state_reg      <= ST_WAIT;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Bus pins come straight from the held cycle register
  assign o_bus = cyc_reg;

endmodule : cpu_space_bus_termination

// ### bus_term_checker_assertions.sv
// Checker for CPU-space encodings and cycle terminations
module bus_term_checker
  import cpu_space_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_nrst,
  input wire bus_req_t   i_req,
  input wire logic       o_req_ready,
  input wire logic [1:0] i_data_size_acknowledge_n,
  input wire logic       i_bus_error_input_n,
  input wire logic       i_halt_n,
  input wire bus_out_t   o_bus,
  input wire logic       o_done,
  input wire term_t      o_term,
  input wire logic       o_pipe_insert,
  input wire logic       o_halted
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  req_kind_t   kind_reg;
  logic [31:0] addr_reg;
  logic        pins;
  // Kind and address of the cycle in flight, kept so a reissue can be compared
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      kind_reg <= REQ_OTHER;
      addr_reg <= 32'h0000_0000;
    end else if (o_req_ready) begin
      kind_reg <= i_req.kind;
      addr_reg <= o_bus.addr;
    end
  end
  // Any terminating pin active
  assign pins = (i_data_size_acknowledge_n != 2'b11) || !i_bus_error_input_n;
  a_fc_cpu_space: assert property (o_req_ready && i_req.kind != REQ_OTHER |->
    o_bus.strobe && o_bus.fc == FC_CPU_SPACE) else $error("cpu space code wrong");
  a_breakpoint_instruction_fields: assert property (o_req_ready && i_req.kind == REQ_BREAKPOINT_INSTRUCTION |->
    o_bus.addr[19:16] == TYPE_BREAKPOINT_INSTRUCTION && o_bus.addr[4:2] == i_req.breakpoint_instruction_num && o_bus.read)
    else $error("breakpoint address wrong");
  a_coproc_fields: assert property (o_req_ready && i_req.kind == REQ_COPROC |->
    o_bus.addr[19:16] == TYPE_COPROC && o_bus.addr[15:13] == i_req.coprocessor_identifier
    && o_bus.addr[5:0] == i_req.reg_sel[5:0]) else $error("coprocessor address wrong");
  a_access_fields: assert property (o_req_ready && i_req.kind == REQ_ACCESS |->
    o_bus.addr[19:16] == TYPE_ACCESS && o_bus.addr[7:0] == i_req.reg_sel)
    else $error("access level address wrong");
  a_done_cause: assert property (o_done |-> $past(pins, 3))
    else $error("cycle ended without a terminating pin");
  a_insert_normal: assert property (o_pipe_insert |-> o_done && o_term == TERM_NORMAL
    && kind_reg == REQ_BREAKPOINT_INSTRUCTION) else $error("pipeline insert without good breakpoint word");
  a_illegal_breakpoint_instruction: assert property (o_done && o_term inside {TERM_ILLEGAL, TERM_BUS_ERR} |->
    (o_term == TERM_ILLEGAL) == (kind_reg == REQ_BREAKPOINT_INSTRUCTION)) else $error("error code wrong");
  a_reissue_same: assert property ($rose(o_bus.strobe) && !o_req_ready |->
    o_bus.addr == addr_reg || o_bus.addr == addr_reg + 32'h0000_0001)
    else $error("reissued cycle address changed");
  a_retry_wait: assert property (!i_halt_n && !i_bus_error_input_n |=>
    !$rose(o_bus.strobe)) else $error("strobe raised during retry request");
  a_bus_error_input_ends: assert property (!i_bus_error_input_n && o_bus.strobe |->
    ##[1:4] !o_bus.strobe) else $error("bus error did not end cycle");
  a_halt_refuse: assert property (o_halted && $past(o_halted) |-> !o_req_ready)
    else $error("request taken while halted");
endmodule : bus_term_checker

// ### bus_responder_model.sv
// Responder on the far side: memory, timeout timer, error-correcting controller
module bus_responder_model
  import cpu_space_pkg::*;
(
  input  wire logic        i_clk,
  input  wire bus_out_t    i_bus,
  input  wire logic [2:0]  i_mode,
  input  wire logic [15:0] i_word,
  output logic [1:0]       o_ack_n,
  output logic             o_bus_error_input_n,
  output logic             o_halt_n,
  output logic [15:0]      o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt = 0;
  int   hold = 0;
  logic retried = 1'b0;
  initial begin
    o_ack_n = 2'b11;
    o_bus_error_input_n = 1'b1;
    o_halt_n = 1'b1;
    o_data = 16'h0000;
  end
  // Modes: 0 word, 1 byte port, 2 timeout error, 3 retry, 4 late error, 5 late retry, 6 halt
  // Pins move on the rising edge only, so joint terminations land together
  always @(posedge i_clk) begin
    cnt <= i_bus.strobe ? cnt + 1 : 0;
    if (i_bus.strobe && cnt == 3) begin
      if (i_mode inside {3'h2, 3'h3} && !retried) begin
        o_bus_error_input_n <= 1'b0;
        o_halt_n <= (i_mode != 3'h3);
      end else begin
        o_ack_n <= (i_mode == 3'h1) ? 2'b10 : 2'b01;
        o_data <= (i_mode != 3'h1) ? i_word : {(i_bus.addr[0] ? i_word[7:0] : i_word[15:8]), 8'h5A};
        o_halt_n <= (i_mode != 3'h6);
      end
    end
    // Early acknowledge, then bad data flagged one clock later
    if (i_bus.strobe && cnt == 4 && i_mode inside {3'h4, 3'h5} && !retried) begin
      o_bus_error_input_n <= 1'b0;
      o_halt_n <= (i_mode != 3'h5);
    end
    // Release together once strobe drops; halt only later in halt mode
    if (!i_bus.strobe && cnt != 0) begin
      o_ack_n <= 2'b11;
      o_bus_error_input_n <= 1'b1;
      o_data <= ~o_data;
      o_halt_n <= (i_mode != 3'h6);
      hold <= 12;
      retried <= i_mode inside {3'h3, 3'h5} && !retried;
    end else if (!i_bus.strobe && hold > 0) begin
      hold <= hold - 1;
      if (hold == 1) o_halt_n <= 1'b1;
    end
  end
endmodule : bus_responder_model

// ### tb.sv
// Testbench: CPU-space cycles and every termination case
module tb;
  import cpu_space_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_sys_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_req_valid = 1'b0;
  bus_req_t    i_req = '0;
  logic [2:0]  mode = 3'h0;
  logic [15:0] word = 16'hC3A5;
  logic [1:0]  ack_n;
  logic        bus_error_input_n, halt_n, ready, done, ins, halted, stb_q = 1'b0;
  logic [15:0] data, rd, g_rd;
  bus_out_t    bus;
  term_t       term, g_term;
  logic [31:0] g_addr;
  logic [2:0]  g_fc;
  logic        g_ins;
  int          fail_count = 0, compares = 0, cycles = 0, nstb = 0, n, g_wait;
  cpu_space_bus_termination cpu_space_bus_termination_inst (.i_sys_clk, .i_nrst,
    .i_clk_en(1'b1), .i_req_valid, .i_req, .o_req_ready(ready),
    .i_data_size_acknowledge_n(ack_n), .i_bus_error_input_n(bus_error_input_n), .i_halt_n(halt_n),
    .i_data(data), .o_bus(bus), .o_done(done), .o_term(term), .o_rd_data(rd),
    .o_pipe_insert(ins), .o_halted(halted));
  bus_responder_model bus_responder_model_inst (.i_clk(i_sys_clk), .i_bus(bus),
    .i_mode(mode), .i_word(word), .o_ack_n(ack_n), .o_bus_error_input_n(bus_error_input_n), .o_halt_n(halt_n),
    .o_data(data));
  initial forever #25 i_sys_clk = ~i_sys_clk;
  // Strobe count per cycle and hang guard
  always @(posedge i_sys_clk) begin
    stb_q <= bus.strobe;
    if (bus.strobe && !stb_q) nstb <= nstb + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      $display("MISMATCH %0t timeout", $time);
      results();
    end
  end
  task automatic chk_term(input term_t got, input term_t exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t term %0d expected %0d", $time, got, exp);
    end
  endtask : chk_term
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t value %0h expected %0h", $time, got, exp);
    end
  endtask : chk_val
  function automatic bus_req_t mk(req_kind_t k, logic [2:0] id, logic [7:0] sel);
    return '{k, 3'h1, 32'h0000_0000, id, id, sel, SIZE_WORD, 1'b1};
  endfunction : mk
  // One whole cycle: hold valid until taken, then wait for a final end (not a retry)
  task automatic run(input bus_req_t r, input logic [2:0] m);
    mode = m;
    nstb = 0;
    i_req = r;
    i_req_valid = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 60) begin
      @(negedge i_sys_clk);
      n++;
    end
    g_wait = n;
    // A request never taken is a hang, not a pass
    if (ready !== 1'b1) begin
      fail_count++;
      $display("MISMATCH %0t request not taken", $time);
    end
    g_addr = bus.addr;
    g_fc = bus.fc;
    i_req_valid = 1'b0;
    while (!(done === 1'b1 && term !== TERM_RETRY) && n < 400) begin
      @(negedge i_sys_clk);
      n++;
    end
    // Running out of the wait limit counts against the run
    if (done !== 1'b1) begin
      fail_count++;
      $display("MISMATCH %0t cycle never ended", $time);
    end
    g_term = term;
    g_rd = rd;
    g_ins = ins;
    repeat (4) @(negedge i_sys_clk);
  endtask : run
  task automatic t_breakpoint_instruction;
    run(mk(REQ_BREAKPOINT_INSTRUCTION, 3'h5, 8'h00), 3'h0);
    chk_val({g_fc, g_addr[19:16], g_addr[4:2]}, {FC_CPU_SPACE, TYPE_BREAKPOINT_INSTRUCTION, 3'h5});
    chk_term(g_term, TERM_NORMAL);
    chk_val({g_ins, g_rd}, {1'b1, word});
    run(mk(REQ_BREAKPOINT_INSTRUCTION, 3'h2, 8'h00), 3'h1);
    chk_val({nstb[3:0], g_rd}, {4'h2, word});
    run(mk(REQ_BREAKPOINT_INSTRUCTION, 3'h7, 8'h00), 3'h2);
    chk_term(g_term, TERM_ILLEGAL);
  endtask : t_breakpoint_instruction
  task automatic t_coproc;
    for (int i = 0; i < 8; i++) begin
      run(mk(REQ_COPROC, i[2:0], {2'h2, ~i[2:0], i[2:0]}), 3'h0);
      chk_val({g_fc, g_addr[19:13], g_addr[5:0]}, {FC_CPU_SPACE, TYPE_COPROC, i[2:0], ~i[2:0], i[2:0]});
    end
    run(mk(REQ_ACCESS, MMU_COPROCESSOR_IDENTIFIER, 8'hA5), 3'h2);
    chk_val({g_addr[19:16], g_addr[7:0]}, {TYPE_ACCESS, 8'hA5});
    chk_term(g_term, TERM_BUS_ERR);
    run(mk(REQ_COPROC, 3'h3, 8'h11), 3'h4);
    chk_term(g_term, TERM_BUS_ERR);
  endtask : t_coproc
  // Retry early and late: a second strobe, then a normal end
  task automatic t_retry;
    for (int m = 3; m <= 5; m += 2) begin
      run(mk(REQ_ACCESS, 3'h0, 8'h3C), m[2:0]);
      chk_val(nstb, 2);
      chk_term(g_term, TERM_NORMAL);
    end
  endtask : t_retry
  task automatic t_halt;
    run(mk(REQ_COPROC, 3'h1, 8'h02), 3'h6);
    chk_term(g_term, TERM_NORMAL);
    chk_val(halted, 1);
    run(mk(REQ_COPROC, 3'h1, 8'h03), 3'h0);
    chk_val(g_wait > 4, 1);
  endtask : t_halt
  task automatic results;
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (3) @(negedge i_sys_clk);
    i_nrst = 1'b1;
    t_breakpoint_instruction();
    t_coproc();
    t_retry();
    t_halt();
    results();
  end
endmodule : tb
bind cpu_space_bus_termination bus_term_checker bus_term_checker_inst (.i_sys_clk, .i_nrst,
  .i_req, .o_req_ready, .i_data_size_acknowledge_n, .i_bus_error_input_n, .i_halt_n,
  .o_bus, .o_done, .o_term, .o_pipe_insert, .o_halted);
